// *** logic/tcc_pkg.sv ***
// Constants, field positions and carrier types of the 16-bit timer core
package tcc_pkg;

  // Counter width and fixed values of the count sequence
  localparam int          CNT_W      = 16;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX8   = 16'h00ff;
  localparam logic [15:0] CNT_MAX16  = 16'hffff;
  localparam logic [15:0] CNT_ONE    = 16'h0001;

  // Clock select codes, ascending
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_DIV1     = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV64    = 3'h3;
  localparam logic [2:0] CS_DIV256   = 3'h4;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Prescaler width and tap masks
  localparam int         PRE_W     = 10;
  localparam logic [9:0] PRE_ONE   = 10'h001;
  localparam logic [9:0] DIV8_M    = 10'h007;
  localparam logic [9:0] DIV64_M   = 10'h03f;
  localparam logic [9:0] DIV256_M  = 10'h0ff;
  localparam logic [9:0] DIV1024_M = 10'h3ff;

  // Field positions in timer_control_a and timer_control_b
  localparam int CA_COMA_LSB = 6;
  localparam int CA_COMB_LSB = 4;
  localparam int CA_WGML_LSB = 0;
  localparam int CB_NC_BIT   = 7;
  localparam int CB_EDGE_BIT = 6;
  localparam int CB_WGMH_LSB = 3;
  localparam int CB_CS_LSB   = 0;

  // Compare output actions
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TGL = 2'h1;
  localparam logic [1:0] COM_CLR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  // Waveform generation modes served
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_PC8    = 4'h1;
  localparam logic [3:0] WGM_CTC_A  = 4'h4;
  localparam logic [3:0] WGM_FAST8  = 4'h5;
  localparam logic [3:0] WGM_PC_I   = 4'ha;
  localparam logic [3:0] WGM_PC_A   = 4'hb;
  localparam logic [3:0] WGM_CTC_I  = 4'hc;
  localparam logic [3:0] WGM_FAST_I = 4'he;
  localparam logic [3:0] WGM_FAST_A = 4'hf;

  // Bit positions in timer_flag_reg and timer_mask_reg
  localparam int FLG_OVF  = 0;
  localparam int FLG_CMPA = 1;
  localparam int FLG_CMPB = 2;
  localparam int FLG_CAPT = 3;
  localparam int FLG_W    = 4;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] FLG_RST  = 4'h0;

  // Capture noise filter depth
  localparam int FLT_DEPTH = 4;

  // Byte locations that the CPU can address
  typedef enum logic [3:0] {
    SEL_CNT_L  = 4'h0,
    SEL_CNT_H  = 4'h1,
    SEL_OCRA_L = 4'h2,
    SEL_OCRA_H = 4'h3,
    SEL_OCRB_L = 4'h4,
    SEL_OCRB_H = 4'h5,
    SEL_ICR_L  = 4'h6,
    SEL_ICR_H  = 4'h7,
    SEL_CTRL_A = 4'h8,
    SEL_CTRL_B = 4'h9,
    SEL_FLAG   = 4'ha,
    SEL_MASK   = 4'hb
  } tcc_sel_e;

  // One CPU byte access
  typedef struct packed {
    logic       rd;
    logic       wr;
    tcc_sel_e   sel;
    logic [7:0] wdata;
  } tcc_cpu_req_s;

endpackage : tcc_pkg

// *** logic/tcc_capture_filter.sv ***
// Capture source select, optional noise filter and edge detector
module tcc_capture_filter #(
  parameter int DEPTH = tcc_pkg::FLT_DEPTH
) (
  // Clock and synchronised reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Sources and configuration
  input  wire logic capture_in_pin,
  input  wire logic comparator_out,
  input  wire logic from_cmp,
  input  wire logic flt_en,
  input  wire logic rise_sel,
  input  wire logic active,
  // Qualified edge, one cycle
  output logic      cap_evt
);

  typedef struct packed {
    logic [DEPTH-1:0] hist;
    logic             filt;
    logic             prev;
  } tcc_flt_s;

  tcc_flt_s s_r;
  tcc_flt_s s_nxt;
  logic     lvl;

  // The shift and equality test need at least two samples
  if (DEPTH < 2) begin : g_chk
    $error("tcc_capture_filter: DEPTH below 2");
  end

  // Filtered level moves only when every sample agrees
  always_comb begin
    s_nxt      = s_r;
    s_nxt.hist = {s_r.hist[DEPTH-2:0],
                  (from_cmp ? comparator_out : capture_in_pin)};
    if ((&s_r.hist) || !(|s_r.hist)) begin
      s_nxt.filt = s_r.hist[DEPTH-1];
    end
    lvl        = flt_en ? s_r.filt : s_r.hist[0];
    s_nxt.prev = lvl;
    cap_evt    = active && (rise_sel ? (lvl && !s_r.prev)
                                     : (!lvl && s_r.prev));
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  a_filter_spike: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (!(&s_r.hist) && (|s_r.hist)) |=> (s_r.filt == $past(s_r.filt)))
    else $error("Filter level moved on unequal samples");

  a_edge_single: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cap_evt |=> !cap_evt)
    else $error("Capture edge lasted two cycles");

endmodule : tcc_capture_filter

// *** logic/tcc_timer_core.sv ***
// 16-bit timer/counter core with compare, capture and byte access
// Overview of operation
// - Counter, two compares and capture are 16 bits, reached bytewise.
// - Both control registers are plain 8-bit, read/write at any time.
// - Every request sets its flag bit; its mask bit gates only the request output.
// - Timer tick comes from the prescaler or external pin edges.
// - Clock select zero stops all counting and count-driven flags.
// - CPU reads and writes the counter whether or not it runs.
// - A CPU counter write beats a coincident clear or count step.
// - Each tick clears, increments or decrements by mode.
// - Compare registers are double buffered and compared on every tick but the first after a counter write.
// - A compare match sets that channel's match flag.
// - Compare results drive PWM or frequency output per channel.
// - A qualifying capture edge copies the counter to capture value.
// - Optional digital filter rejects spikes before the edge detector.
// - TOP is fixed 0xFF or 0xFFFF, compare A, or capture value by mode.
// - Compare A as PWM TOP drives no output; its buffer retimes TOP.
// - Capture value can be TOP, leaving compare A free for PWM.
// - BOTTOM is signalled at zero; MAX is 0xFFFF.
// - A 3-bit clock select field in control B drives the selector.
// - Core steps by one, has direction and clear, shows TOP/BOTTOM.
// - Reading a low byte latches its high byte into the temporary.
// - High byte locations read and write the temporary register.
// - Low byte write loads temporary and data in one cycle; capture value only while it is TOP.
// - Overflow flag point depends on the waveform mode.
// - Match flag sets on the tick after counter equals compare.
module tcc_timer_core (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                reset_n,
  // CPU byte access
  input  wire tcc_pkg::tcc_cpu_req_s cpu_req,
  output logic [7:0]               cpu_rdata,
  // Pins
  input  wire logic                ext_count_pin,
  input  wire logic                capture_in_pin,
  input  wire logic                comparator_out,
  input  wire logic                capture_from_cmp,
  output logic [1:0]               compare_out_pins,
  // Interrupt requests and indications
  output logic [3:0]               irq_req,
  output logic                     top_ind,
  output logic                     bottom_ind
);

  typedef struct packed {
    logic [15:0]       cnt;
    logic              down;
    logic [7:0]        temp;
    logic [1:0][15:0]  ocr_buf;
    logic [1:0][15:0]  ocr_act;
    logic [15:0]       icr;
    logic [7:0]        ctrl_a;
    logic [7:0]        ctrl_b;
    logic [3:0]        flags;
    logic [3:0]        mask;
    logic [9:0]        pre;
    logic              ext_prev;
    logic              blk;
    logic [1:0]        oc;
    logic [7:0]        rdata;
    logic [3:0]        irq;
    logic              at_top;
    logic              at_bottom;
  } tcc_core_s;

  tcc_core_s   s_r, s_nxt;
  logic        rst_meta_r, rst_n_r;
  logic [2:0]  cs;
  logic [3:0]  wgm, fset, fclr;
  logic [15:0] top;
  logic [1:0]  hit, com;
  logic        tick, pc, fast, icr_top, a_is_top, upd, cap_evt, cnt_wr;

  // Reset release through two flops, assertion stays asynchronous
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // Capture input is dead while the capture value defines TOP
  tcc_capture_filter #(.DEPTH(tcc_pkg::FLT_DEPTH)) u_capture (
    .core_clk       (core_clk),
    .rst_n          (rst_n_r),
    .capture_in_pin (capture_in_pin),
    .comparator_out (comparator_out),
    .from_cmp       (capture_from_cmp),
    .flt_en         (s_r.ctrl_b[tcc_pkg::CB_NC_BIT]),
    .rise_sel       (s_r.ctrl_b[tcc_pkg::CB_EDGE_BIT]),
    .active         (!icr_top),
    .cap_evt        (cap_evt)
  );

  // Next state: tick, compare, counting, capture, then CPU access
  always_comb begin
    s_nxt  = s_r;
    fset   = '0;
    fclr   = '0;
    hit    = '0;
    com    = tcc_pkg::COM_OFF;
    cs     = s_r.ctrl_b[tcc_pkg::CB_CS_LSB +: 3];
    wgm    = {s_r.ctrl_b[tcc_pkg::CB_WGMH_LSB +: 2],
              s_r.ctrl_a[tcc_pkg::CA_WGML_LSB +: 2]};
    cnt_wr = cpu_req.wr && (cpu_req.sel == tcc_pkg::SEL_CNT_L);

    // Timer tick source; stop code yields no tick at all
    s_nxt.pre      = s_r.pre + tcc_pkg::PRE_ONE;
    s_nxt.ext_prev = ext_count_pin;
    case (cs)
      tcc_pkg::CS_STOP:     tick = 1'b0;
      tcc_pkg::CS_DIV1:     tick = 1'b1;
      tcc_pkg::CS_DIV8:     tick = &(s_r.pre | ~tcc_pkg::DIV8_M);
      tcc_pkg::CS_DIV64:    tick = &(s_r.pre | ~tcc_pkg::DIV64_M);
      tcc_pkg::CS_DIV256:   tick = &(s_r.pre | ~tcc_pkg::DIV256_M);
      tcc_pkg::CS_DIV1024:  tick = &(s_r.pre | ~tcc_pkg::DIV1024_M);
      tcc_pkg::CS_EXT_FALL: tick = s_r.ext_prev && !ext_count_pin;
      tcc_pkg::CS_EXT_RISE: tick = !s_r.ext_prev && ext_count_pin;
      default:              tick = 1'b0;
    endcase

    // TOP source and mode class
    case (wgm)
      tcc_pkg::WGM_PC8,
      tcc_pkg::WGM_FAST8:  top = tcc_pkg::CNT_MAX8;
      tcc_pkg::WGM_CTC_A,
      tcc_pkg::WGM_PC_A,
      tcc_pkg::WGM_FAST_A: top = s_r.ocr_act[0];
      tcc_pkg::WGM_PC_I,
      tcc_pkg::WGM_CTC_I,
      tcc_pkg::WGM_FAST_I: top = s_r.icr;
      default:             top = tcc_pkg::CNT_MAX16;
    endcase
    pc       = (wgm == tcc_pkg::WGM_PC8) || (wgm == tcc_pkg::WGM_PC_I)
               || (wgm == tcc_pkg::WGM_PC_A);
    fast     = (wgm == tcc_pkg::WGM_FAST8)
               || (wgm == tcc_pkg::WGM_FAST_I)
               || (wgm == tcc_pkg::WGM_FAST_A);
    icr_top  = (wgm == tcc_pkg::WGM_PC_I) || (wgm == tcc_pkg::WGM_CTC_I)
               || (wgm == tcc_pkg::WGM_FAST_I);
    a_is_top = (wgm == tcc_pkg::WGM_PC_A) || (wgm == tcc_pkg::WGM_FAST_A);

    // Buffered compare values: live in plain modes, at TOP in PWM
    upd = !(pc || fast) || (tick && (s_r.cnt == top));
    if (upd) begin
      s_nxt.ocr_act = s_r.ocr_buf;
    end

    // Compare and waveform per channel, judged on the pre-step value
    for (int i = 0; i < 2; i++) begin
      hit[i] = tick && !s_r.blk
               && (s_r.cnt == s_r.ocr_act[i]);
      if (hit[i]) begin
        fset[(i == 0) ? tcc_pkg::FLG_CMPA
                      : tcc_pkg::FLG_CMPB] = 1'b1;
      end
      com = s_r.ctrl_a[((i == 0) ? tcc_pkg::CA_COMA_LSB
                                 : tcc_pkg::CA_COMB_LSB) +: 2];
      // Compare A as PWM TOP holds its pin
      if ((com != tcc_pkg::COM_OFF) && !(i == 0 && a_is_top)) begin
        if (!(pc || fast)) begin
          if (hit[i]) begin
            case (com)
              tcc_pkg::COM_TGL: s_nxt.oc[i] = !s_r.oc[i];
              tcc_pkg::COM_CLR: s_nxt.oc[i] = 1'b0;
              default:          s_nxt.oc[i] = 1'b1;
            endcase
          end
        end else if (com != tcc_pkg::COM_TGL) begin
          if (fast && tick && (s_r.cnt == top)) begin
            s_nxt.oc[i] = (com == tcc_pkg::COM_CLR);
          end
          if (fast && hit[i]) begin
            s_nxt.oc[i] = (com == tcc_pkg::COM_SET);
          end
          if (pc && hit[i]) begin
            s_nxt.oc[i] = (com == tcc_pkg::COM_CLR) ? s_r.down
                                                    : !s_r.down;
          end
        end
      end
    end

    // Count step; a write in the same cycle overrides it below
    if (tick) begin
      s_nxt.blk = 1'b0;
      if (pc) begin
        if (s_r.down) begin
          if (s_r.cnt == tcc_pkg::CNT_BOTTOM) begin
            s_nxt.down            = 1'b0;
            s_nxt.cnt             = s_r.cnt + tcc_pkg::CNT_ONE;
            fset[tcc_pkg::FLG_OVF] = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt - tcc_pkg::CNT_ONE;
          end
        end else if (s_r.cnt >= top) begin
          s_nxt.down = 1'b1;
          s_nxt.cnt  = s_r.cnt - tcc_pkg::CNT_ONE;
        end else begin
          s_nxt.cnt = s_r.cnt + tcc_pkg::CNT_ONE;
        end
      end else begin
        // CTC above TOP runs on to MAX and wraps
        s_nxt.cnt = (s_r.cnt == top) ? tcc_pkg::CNT_BOTTOM
                                     : s_r.cnt + tcc_pkg::CNT_ONE;
        fset[tcc_pkg::FLG_OVF] = fast ? (s_r.cnt == top)
                                      : (s_r.cnt == tcc_pkg::CNT_MAX16);
      end
    end

    // Capture takes the counter and flags in the same clock
    if (cap_evt && !icr_top) begin
      s_nxt.icr               = s_r.cnt;
      fset[tcc_pkg::FLG_CAPT] = 1'b1;
    end

    // CPU write, last so it wins over count and clear
    if (cpu_req.wr) begin
      case (cpu_req.sel)
        tcc_pkg::SEL_CNT_H, tcc_pkg::SEL_OCRA_H,
        tcc_pkg::SEL_OCRB_H, tcc_pkg::SEL_ICR_H:
          s_nxt.temp = cpu_req.wdata;
        tcc_pkg::SEL_CNT_L: begin
          s_nxt.cnt = {s_r.temp, cpu_req.wdata};
          s_nxt.blk = 1'b1;
        end
        tcc_pkg::SEL_OCRA_L: s_nxt.ocr_buf[0] = {s_r.temp, cpu_req.wdata};
        tcc_pkg::SEL_OCRB_L: s_nxt.ocr_buf[1] = {s_r.temp, cpu_req.wdata};
        tcc_pkg::SEL_ICR_L: begin
          if (icr_top) begin
            s_nxt.icr = {s_r.temp, cpu_req.wdata};
          end
        end
        tcc_pkg::SEL_CTRL_A: s_nxt.ctrl_a = cpu_req.wdata;
        tcc_pkg::SEL_CTRL_B: s_nxt.ctrl_b = cpu_req.wdata;
        tcc_pkg::SEL_FLAG:   fclr = cpu_req.wdata[tcc_pkg::FLG_W-1:0];
        tcc_pkg::SEL_MASK:
          s_nxt.mask = cpu_req.wdata[tcc_pkg::FLG_W-1:0];
        default: ;
      endcase
    end

    // CPU read; low byte latches its high byte for the next access
    if (cpu_req.rd) begin
      case (cpu_req.sel)
        tcc_pkg::SEL_CNT_L:  {s_nxt.temp, s_nxt.rdata} = s_r.cnt;
        tcc_pkg::SEL_OCRA_L: {s_nxt.temp, s_nxt.rdata} = s_r.ocr_buf[0];
        tcc_pkg::SEL_OCRB_L: {s_nxt.temp, s_nxt.rdata} = s_r.ocr_buf[1];
        tcc_pkg::SEL_ICR_L:  {s_nxt.temp, s_nxt.rdata} = s_r.icr;
        tcc_pkg::SEL_CNT_H, tcc_pkg::SEL_OCRA_H, tcc_pkg::SEL_OCRB_H,
        tcc_pkg::SEL_ICR_H:  s_nxt.rdata = s_r.temp;
        tcc_pkg::SEL_CTRL_A: s_nxt.rdata = s_r.ctrl_a;
        tcc_pkg::SEL_CTRL_B: s_nxt.rdata = s_r.ctrl_b;
        tcc_pkg::SEL_FLAG:   s_nxt.rdata = {4'h0, s_r.flags};
        tcc_pkg::SEL_MASK:   s_nxt.rdata = {4'h0, s_r.mask};
        default:             s_nxt.rdata = 8'h00;
      endcase
    end

    // Set wins over a write-one clear in the same cycle
    s_nxt.flags     = (s_r.flags & ~fclr) | fset;
    s_nxt.irq       = s_nxt.flags & s_nxt.mask;
    s_nxt.at_top    = (s_nxt.cnt == top);
    s_nxt.at_bottom = (s_nxt.cnt == tcc_pkg::CNT_BOTTOM);
  end

  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s_r        <= '0;
      s_r.ctrl_a <= tcc_pkg::CTRL_RST;
      s_r.ctrl_b <= tcc_pkg::CTRL_RST;
      s_r.flags  <= tcc_pkg::FLG_RST;
      s_r.at_bottom <= 1'b1;             // Cleared counter already sits at BOTTOM
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state flops
  assign cpu_rdata        = s_r.rdata;
  assign compare_out_pins = s_r.oc;
  assign irq_req          = s_r.irq;
  assign top_ind          = s_r.at_top;
  assign bottom_ind       = s_r.at_bottom;

  a_stop_holds: assert property (
    @(posedge core_clk) disable iff (!rst_n_r)
    (cs == tcc_pkg::CS_STOP && !cnt_wr && !cap_evt)
      |=> (s_r.cnt == $past(s_r.cnt)) && (!s_r.flags[tcc_pkg::FLG_OVF]
          || $past(s_r.flags[tcc_pkg::FLG_OVF])))
    else $error("Stopped counter moved");
  a_write_wins: assert property (
    @(posedge core_clk) disable iff (!rst_n_r)
    cnt_wr |=> s_r.cnt == {$past(s_r.temp), $past(cpu_req.wdata)})
    else $error("Counter write lost to count step");
  a_low_latch: assert property (
    @(posedge core_clk) disable iff (!rst_n_r)
    (cpu_req.rd && cpu_req.sel == tcc_pkg::SEL_CNT_L)
      |=> s_r.temp == $past(s_r.cnt[15:8]))
    else $error("Low read did not latch high byte");
  a_high_read: assert property (
    @(posedge core_clk) disable iff (!rst_n_r)
    (cpu_req.rd && cpu_req.sel == tcc_pkg::SEL_CNT_H)
      |=> cpu_rdata == $past(s_r.temp))
    else $error("High read did not return temporary");
  a_high_temp: assert property (
    @(posedge core_clk) disable iff (!rst_n_r)
    (cpu_req.wr && cpu_req.sel == tcc_pkg::SEL_CNT_H)
      |=> s_r.temp == $past(cpu_req.wdata))
    else $error("High byte write missed temporary");
  a_match_flag: assert property (
    @(posedge core_clk) disable iff (!rst_n_r)
    (tick && !s_r.blk && s_r.cnt == s_r.ocr_act[0])
      |=> s_r.flags[tcc_pkg::FLG_CMPA])
    else $error("Compare A match did not set flag");
  a_capture_copy: assert property (
    @(posedge core_clk) disable iff (!rst_n_r)
    (cap_evt && !icr_top)
      |=> s_r.icr == $past(s_r.cnt) && s_r.flags[tcc_pkg::FLG_CAPT])
    else $error("Capture did not copy counter");
  a_irq_gate: assert property (
    @(posedge core_clk) disable iff (!rst_n_r)
    !s_r.mask[tcc_pkg::FLG_OVF] |-> !irq_req[tcc_pkg::FLG_OVF])
    else $error("Masked overflow raised request");
  a_ctrl_write: assert property (
    @(posedge core_clk) disable iff (!rst_n_r)
    (cpu_req.wr && cpu_req.sel == tcc_pkg::SEL_CTRL_B)
      |=> s_r.ctrl_b == $past(cpu_req.wdata))
    else $error("Control B write not taken");
  a_bottom_ind: assert property (
    @(posedge core_clk) disable iff (!rst_n_r)
    bottom_ind == (s_r.cnt == tcc_pkg::CNT_BOTTOM))
    else $error("Bottom indication wrong");

endmodule : tcc_timer_core

// *** tb/tcc_cpu_model.sv ***
// CPU-side byte access model for the timer core request port
module tcc_cpu_model (
  // Clock
  input  wire logic             core_clk,
  // Request and answer
  output tcc_pkg::tcc_cpu_req_s cpu_req,
  input  wire logic [7:0]       cpu_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus from time zero
  initial cpu_req = '0;

  // Byte write, strobe held for exactly one taking edge
  task automatic wr(input tcc_pkg::tcc_sel_e sel, input logic [7:0] d);
    @(posedge core_clk);
    cpu_req <= '{rd: 1'b0, wr: 1'b1, sel: sel, wdata: d};
    @(posedge core_clk);
    cpu_req.wr <= 1'b0;
  endtask : wr

  // Byte read; data is sampled once it has settled
  task automatic rd(input tcc_pkg::tcc_sel_e sel, output logic [7:0] d);
    @(posedge core_clk);
    cpu_req <= '{rd: 1'b1, wr: 1'b0, sel: sel, wdata: 8'h00};
    @(posedge core_clk);
    cpu_req.rd <= 1'b0;
    @(posedge core_clk);
    #1;
    d = cpu_rdata;
  endtask : rd

  // High byte goes first so the shared temporary holds the upper bits
  task automatic wr16(input tcc_pkg::tcc_sel_e lo, input logic [15:0] v);
    wr(tcc_pkg::tcc_sel_e'(lo + 4'h1), v[15:8]);
    wr(lo, v[7:0]);
  endtask : wr16

  // Low byte first: it latches the high byte into the temporary
  task automatic rd16(input tcc_pkg::tcc_sel_e lo, output logic [15:0] v);
    logic [7:0] l;
    logic [7:0] h;
    rd(lo, l);
    rd(tcc_pkg::tcc_sel_e'(lo + 4'h1), h);
    v = {h, l};
  endtask : rd16
endmodule : tcc_cpu_model

// *** tb/tb_top.sv ***
// Self-checking bench for the 16-bit timer core
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // Clock, reset, pins and observed outputs
  logic                  core_clk = 1'b0;
  logic                  reset_n  = 1'b0;
  logic                  ext_pin  = 1'b0;
  logic                  cap_pin  = 1'b0;
  logic                  cmp_sel  = 1'b0;
  logic                  cmp_out  = 1'b0;
  tcc_pkg::tcc_cpu_req_s cpu_req;
  logic [7:0]            cpu_rdata;
  logic [1:0]            cmp_pins;
  logic [3:0]            irq;
  logic                  top_ind;
  logic                  bottom_ind;
  logic [15:0]           v16;
  logic [7:0]            v8;
  int                    err_total  = 0;
  int                    n_compared = 0;
  int                    cyc        = 0;

  always #5 core_clk = ~core_clk;

  // Comparator source is switched in by the last scenario
  tcc_timer_core dut_u (
    .core_clk(core_clk), .reset_n(reset_n), .cpu_req(cpu_req),
    .cpu_rdata(cpu_rdata), .ext_count_pin(ext_pin),
    .capture_in_pin(cap_pin), .comparator_out(cmp_out),
    .capture_from_cmp(cmp_sel), .compare_out_pins(cmp_pins),
    .irq_req(irq), .top_ind(top_ind), .bottom_ind(bottom_ind));
  tcc_cpu_model cpu_u (
    .core_clk(core_clk), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // One pulse per step; margin lets the last edge land
  task automatic ext_edges(input int n);
    repeat (n) begin
      @(posedge core_clk);
      ext_pin <= 1'b1;
      @(posedge core_clk);
      ext_pin <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
  endtask : ext_edges

  task automatic cap_pulse(input int n);
    @(posedge core_clk);
    cap_pin <= 1'b1;
    repeat (n) @(posedge core_clk);
    cap_pin <= 1'b0;
    repeat (10) @(posedge core_clk);
  endtask : cap_pulse

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  initial begin
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    cpu_u.rd(tcc_pkg::SEL_CTRL_A, v8);
    check(16'(v8), 16'h0000);
    cpu_u.wr(tcc_pkg::SEL_CTRL_A, 8'h30);
    cpu_u.rd(tcc_pkg::SEL_CTRL_A, v8);
    check(16'(v8), 16'h0030);
    cpu_u.wr(tcc_pkg::SEL_MASK, 8'h0f);
    cpu_u.wr16(tcc_pkg::SEL_CNT_L, 16'h1234);
    cpu_u.rd16(tcc_pkg::SEL_CNT_L, v16);
    check(v16, 16'h1234);
    // Both external edge codes, then a stopped counter ignores edges
    for (int cs = 6; cs < 8; cs++) begin
      cpu_u.wr16(tcc_pkg::SEL_CNT_L, 16'h0100);
      cpu_u.wr(tcc_pkg::SEL_CTRL_B, 8'(cs));
      ext_edges(5);
      cpu_u.wr(tcc_pkg::SEL_CTRL_B, 8'h00);
      ext_edges(2);
      cpu_u.rd16(tcc_pkg::SEL_CNT_L, v16);
      check(v16, 16'h0105);
    end
    // Write lands in the same cycle as a tick: the step is dropped
    cpu_u.wr(tcc_pkg::SEL_CTRL_B, 8'h07);
    cpu_u.wr(tcc_pkg::SEL_CNT_H, 8'h20);
    fork
      cpu_u.wr(tcc_pkg::SEL_CNT_L, 8'h40);
      begin
        @(posedge core_clk);
        ext_pin <= 1'b1;
        @(posedge core_clk);
        ext_pin <= 1'b0;
      end
    join
    ext_edges(0);
    cpu_u.rd16(tcc_pkg::SEL_CNT_L, v16);
    check(v16, 16'h2040);
    // Compare match flags one tick after equality, B output sets
    cpu_u.wr16(tcc_pkg::SEL_OCRA_L, 16'h0005);
    cpu_u.wr16(tcc_pkg::SEL_OCRB_L, 16'h0006);
    cpu_u.wr16(tcc_pkg::SEL_CNT_L, 16'h0003);
    cpu_u.wr(tcc_pkg::SEL_FLAG, 8'h0f);
    ext_edges(2);
    cpu_u.rd(tcc_pkg::SEL_FLAG, v8);
    check(16'(v8), 16'h0000);
    ext_edges(1);
    cpu_u.rd(tcc_pkg::SEL_FLAG, v8);
    check(16'(v8), 16'h0002);
    ext_edges(1);
    check(16'({cmp_pins[1], irq}), 16'h0016);
    // Wrap to zero sets overflow and bottom
    cpu_u.wr16(tcc_pkg::SEL_CNT_L, 16'hffff);
    cpu_u.wr(tcc_pkg::SEL_FLAG, 8'h0f);
    cpu_u.wr(tcc_pkg::SEL_MASK, 8'h01);
    ext_edges(1);
    cpu_u.rd(tcc_pkg::SEL_FLAG, v8);
    check(16'({bottom_ind, irq, v8}), 16'h1101);
    cpu_u.wr(tcc_pkg::SEL_FLAG, 8'h01);
    cpu_u.rd(tcc_pkg::SEL_FLAG, v8);
    check(16'(v8), 16'h0000);
    // Filtered rising capture, then a spike that must be rejected
    cpu_u.wr(tcc_pkg::SEL_CTRL_B, 8'hc7);
    cpu_u.wr16(tcc_pkg::SEL_CNT_L, 16'h0abc);
    cap_pulse(8);
    cpu_u.wr16(tcc_pkg::SEL_CNT_L, 16'h0def);
    cap_pulse(1);
    cpu_u.rd16(tcc_pkg::SEL_ICR_L, v16);
    check(v16, 16'h0abc);
    cpu_u.rd(tcc_pkg::SEL_FLAG, v8);
    check(16'(v8), 16'h0008);
    // Compare A as TOP in CTC: TOP shown, toggle at match, clear to zero
    cpu_u.wr(tcc_pkg::SEL_CTRL_A, 8'h70);
    cpu_u.wr16(tcc_pkg::SEL_CNT_L, 16'h0004);
    cpu_u.wr(tcc_pkg::SEL_CTRL_B, 8'h0f);
    ext_edges(1);
    check(16'(top_ind), 16'h0001);
    ext_edges(1);
    check(16'(cmp_pins), 16'h0003);
    cpu_u.rd16(tcc_pkg::SEL_CNT_L, v16);
    check(v16, 16'h0000);
    // Comparator output as the capture source, rising edge, no filter
    cpu_u.wr(tcc_pkg::SEL_CTRL_B, 8'h4f);
    cpu_u.wr16(tcc_pkg::SEL_CNT_L, 16'h0077);
    @(posedge core_clk);
    cmp_sel <= 1'b1;
    @(posedge core_clk);
    cmp_out <= 1'b1;
    repeat (5) @(posedge core_clk);
    cpu_u.rd16(tcc_pkg::SEL_ICR_L, v16);
    check(v16, 16'h0077);
    report_and_stop();
  end
endmodule : tb_top
